// ### core/aapc_ctrl.sv
// converter front-end control: routing, equalizer, auxiliary sequencer, clock setup, serial registers
`timescale 1ns/1ps
module aapc_ctrl
  import aapc_pkg::*;
#(
  parameter int SLOT_SLOW_CYC = AUX_SLOT_SLOW_CYC,
  parameter int SLOT_FAST_CYC = AUX_SLOT_FAST_CYC
) (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // serial control port pins
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  // input routing and equalizer
  output aapc_path_t       route_path,
  output logic             route_swap,
  output logic             eq_enable,
  output logic [1:0]       equalizer_cutoff_select,
  output logic             aux_direct_pos_is_one,
  // auxiliary converter
  output logic             aux_conv_start,
  output logic             aux_chan_sel,
  input  wire logic [7:0]  aux_result,
  input  wire logic        aux_result_valid,
  // clock setup
  output logic             clk_src_pll,
  output logic             xtal_osc_en,
  output logic             pll_enable,
  output logic             pll_frac_mode,
  output logic [3:0]       pll_mult_r,
  output logic [3:0]       pll_div_x,
  output logic [15:0]      pll_frac_num,
  output logic [15:0]      pll_frac_den,
  input  wire logic        pll_locked
);

  // writable-register decode used by the write path only; reads use the rd_data chain
  function automatic logic is_rw_reg(input logic [11:0] a);
    is_rw_reg = (a == REG_CLK_SRC) || (a == REG_PLL_FRACTION_DENOMINATOR) || (a == REG_PLL_NUM) ||
                (a == REG_PLL_CTRL) || (a == REG_ROUTE) || (a == REG_AUX_RATE) ||
                (a == REG_AUX_INSEL) || (a == REG_XTAL_EN) || (a == REG_EQ_CTRL);
  endfunction

  // software registers
  logic [15:0] clk_src_r;
  logic [15:0] pll_fraction_denominator_r;
  logic [15:0] pll_num_r;
  logic [15:0] pll_ctrl_r;
  logic [15:0] route_r;
  logic [15:0] aux_rate_r;
  logic [15:0] aux_insel_r;
  logic [15:0] xtal_r;
  logic [15:0] eq_r;
  logic [15:0] aux_cur_r;
  logic [15:0] aux_last_r;

  // pin synchronisers
  logic [1:0]  cs_sync_r;
  logic [2:0]  sclk_sync_r;
  logic [1:0]  mosi_sync_r;
  logic [1:0]  lock_sync_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync_r   <= 2'h3;
      sclk_sync_r <= 3'h7;
      mosi_sync_r <= 2'h0;
      lock_sync_r <= 2'h0;
    end else if (clk_en) begin
      cs_sync_r   <= {cs_sync_r[0], spi_cs_n};
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
      mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
      lock_sync_r <= {lock_sync_r[0], pll_locked};
    end
  end

  wire cs_act    = !cs_sync_r[1];
  wire sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
  wire sclk_fall = !sclk_sync_r[1] && sclk_sync_r[2];
  wire mosi_bit  = mosi_sync_r[1];

  // serial frame engine
  logic [5:0]  bit_cnt_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic        rd_r;
  logic [11:0] addr_r;
  logic        miso_r;
  logic        miso_oe_r;

  wire [15:0] rx_nxt    = {rx_r[14:0], mosi_bit};
  wire        hdr_done  = sclk_rise && (bit_cnt_r == SPI_HDR_BITS - 6'd1);
  wire        frame_end = sclk_rise && (bit_cnt_r == SPI_FRAME_BITS - 6'd1);
  wire [11:0] hdr_addr  = rx_nxt[11:0];
  wire        wr_stb    = cs_act && frame_end && !rd_r && is_rw_reg(addr_r);
  wire [15:0] wr_data   = rx_nxt;

  // read data selection
  logic [15:0] rd_data;
  always_comb begin
    rd_data = 16'h0000;
    if (hdr_addr == REG_CLK_SRC) begin
      rd_data = clk_src_r;
    end else if (hdr_addr == REG_PLL_FRACTION_DENOMINATOR) begin
      rd_data = pll_fraction_denominator_r;
    end else if (hdr_addr == REG_PLL_NUM) begin
      rd_data = pll_num_r;
    end else if (hdr_addr == REG_PLL_CTRL) begin
      rd_data = pll_ctrl_r;
    end else if (hdr_addr == REG_PLL_LOCK) begin
      rd_data[LOCK_BIT] = lock_sync_r[1];
    end else if (hdr_addr == REG_ROUTE) begin
      rd_data = route_r;
    end else if (hdr_addr == REG_AUX_CUR) begin
      rd_data = aux_cur_r;
    end else if (hdr_addr == REG_AUX_LAST) begin
      rd_data = aux_last_r;
    end else if (hdr_addr == REG_AUX_RATE) begin
      rd_data = aux_rate_r;
    end else if (hdr_addr == REG_AUX_INSEL) begin
      rd_data = aux_insel_r;
    end else if (hdr_addr == REG_XTAL_EN) begin
      rd_data = xtal_r;
    end else if (hdr_addr == REG_EQ_CTRL) begin
      rd_data = eq_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= 6'h00;
      rx_r      <= 16'h0000;
      tx_r      <= 16'h0000;
      rd_r      <= 1'b0;
      addr_r    <= 12'h000;
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else if (clk_en) begin
      if (!cs_act) begin
        bit_cnt_r <= 6'h00;
        miso_oe_r <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rx_r      <= rx_nxt;
          bit_cnt_r <= frame_end ? 6'h00 : bit_cnt_r + 6'd1;
        end
        if (hdr_done) begin
          rd_r      <= rx_nxt[15];
          addr_r    <= hdr_addr;
          tx_r      <= rd_data;
          miso_oe_r <= rx_nxt[15];
        end else if (frame_end) begin
          miso_oe_r <= 1'b0;
        end
        if (sclk_fall && miso_oe_r) begin
          miso_r <= tx_r[15];
          tx_r   <= {tx_r[14:0], 1'b0};
        end
      end
    end
  end

  // writable registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_src_r   <= RST_CLK_SRC;
      pll_fraction_denominator_r   <= RST_PLL_FRACTION_DENOMINATOR;
      pll_num_r   <= RST_PLL_NUM;
      pll_ctrl_r  <= RST_PLL_CTRL;
      route_r     <= RST_ROUTE;
      aux_rate_r  <= RST_AUX_RATE;
      aux_insel_r <= RST_AUX_INSEL;
      xtal_r      <= RST_XTAL_EN;
      eq_r        <= RST_EQ_CTRL;
    end else if (clk_en && wr_stb) begin
      if (addr_r == REG_CLK_SRC) begin
        clk_src_r <= wr_data;
      end else if (addr_r == REG_PLL_FRACTION_DENOMINATOR) begin
        pll_fraction_denominator_r <= wr_data;
      end else if (addr_r == REG_PLL_NUM) begin
        pll_num_r <= wr_data;
      end else if (addr_r == REG_PLL_CTRL) begin
        pll_ctrl_r <= wr_data;
      end else if (addr_r == REG_ROUTE) begin
        route_r <= wr_data;
      end else if (addr_r == REG_AUX_RATE) begin
        aux_rate_r <= wr_data;
      end else if (addr_r == REG_AUX_INSEL) begin
        aux_insel_r <= wr_data;
      end else if (addr_r == REG_XTAL_EN) begin
        xtal_r <= wr_data;
      end else if (addr_r == REG_EQ_CTRL) begin
        eq_r <= wr_data;
      end
    end
  end

  // auxiliary sequencer
  localparam int SLOT_W = $clog2(SLOT_SLOW_CYC + 1);
  localparam logic [SLOT_W-1:0] SLOT_SLOW = SLOT_W'(SLOT_SLOW_CYC - 1);
  localparam logic [SLOT_W-1:0] SLOT_FAST = SLOT_W'(SLOT_FAST_CYC - 1);

  logic [SLOT_W-1:0] slot_cnt_r;
  logic              conv_chan_r;
  logic              next_chan_r;
  logic              start_r;

  wire               single_mode = aux_insel_r[AUX_SINGLE_BIT];
  wire               single_chan = aux_insel_r[AUX_SINGLE_IN_BIT];
  wire [SLOT_W-1:0]  slot_last   = aux_rate_r[AUX_RATE_FAST_BIT] ? SLOT_FAST : SLOT_SLOW;
  wire               slot_tick   = (slot_cnt_r >= slot_last);
  // two inputs alternate; one input is converted every slot, i.e. twice the rate
  wire               slot_chan   = single_mode ? single_chan : next_chan_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_cnt_r  <= '0;
      next_chan_r <= 1'b0;
      conv_chan_r <= 1'b0;
      start_r     <= 1'b0;
    end else if (clk_en) begin
      start_r <= slot_tick;
      if (slot_tick) begin
        slot_cnt_r  <= '0;
        conv_chan_r <= slot_chan;
        next_chan_r <= single_mode ? 1'b0 : !next_chan_r;
      end else begin
        slot_cnt_r <= slot_cnt_r + SLOT_W'(1);
      end
    end
  end

  // result registers: previous current value moves to last, then the new byte lands
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_cur_r  <= RST_AUX_RESULT;
      aux_last_r <= RST_AUX_RESULT;
    end else if (clk_en && aux_result_valid) begin
      aux_last_r <= aux_cur_r;
      if (conv_chan_r) begin
        aux_cur_r[AUX_IN2_LSB +: 8] <= aux_result;
      end else begin
        aux_cur_r[AUX_IN1_LSB +: 8] <= aux_result;
      end
    end
  end

  // registered control outputs
  wire        frac_sel = pll_ctrl_r[PLL_FRAC_BIT];
  wire [1:0]  path_sel = route_r[ROUTE_PATH_LSB +: 2];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_path              <= AAPC_PATH_AMP;
      route_swap              <= 1'b0;
      eq_enable               <= 1'b0;
      equalizer_cutoff_select <= EQ_CUT_32K;
      aux_direct_pos_is_one   <= 1'b0;
      aux_conv_start          <= 1'b0;
      aux_chan_sel            <= 1'b0;
      clk_src_pll             <= 1'b0;
      xtal_osc_en             <= 1'b0;
      pll_enable              <= 1'b0;
      pll_frac_mode           <= 1'b0;
      pll_mult_r              <= 4'h0;
      pll_div_x               <= 4'h0;
      pll_frac_num            <= 16'h0000;
      pll_frac_den            <= 16'h0000;
    end else if (clk_en) begin
      route_path              <= aapc_path_t'(path_sel);
      route_swap              <= route_r[ROUTE_SWAP_BIT];
      eq_enable               <= (path_sel == AAPC_PATH_AMP_EQ);
      equalizer_cutoff_select <= eq_r[EQ_CUT_LSB +: 2];
      aux_direct_pos_is_one   <= (path_sel == AAPC_PATH_AUX);
      aux_conv_start          <= start_r;
      aux_chan_sel            <= conv_chan_r;
      clk_src_pll             <= clk_src_r[CLK_SRC_PLL_BIT];
      xtal_osc_en             <= xtal_r[XTAL_EN_BIT];
      pll_enable              <= pll_ctrl_r[PLL_EN_BIT];
      pll_frac_mode           <= frac_sel;
      pll_mult_r              <= pll_ctrl_r[PLL_R_LSB +: PLL_FIELD_W];
      pll_div_x               <= pll_ctrl_r[PLL_X_LSB +: PLL_FIELD_W];
      pll_frac_num            <= frac_sel ? pll_num_r : 16'h0000;
      pll_frac_den            <= frac_sel ? pll_fraction_denominator_r : 16'h0000;
    end
  end

  assign spi_miso_o  = miso_r;
  assign spi_miso_oe = miso_oe_r;

endmodule

// ### shared/aapc_pkg.sv
// register map, field layout, reset values and timing counts for the converter control block
package aapc_pkg;
  // register indices on the serial control port
  localparam logic [11:0] REG_CLK_SRC      = 12'h000;
  localparam logic [11:0] REG_PLL_FRACTION_DENOMINATOR      = 12'h001;
  localparam logic [11:0] REG_PLL_NUM      = 12'h002;
  localparam logic [11:0] REG_PLL_CTRL     = 12'h003;
  localparam logic [11:0] REG_PLL_LOCK     = 12'h005;
  localparam logic [11:0] REG_ROUTE        = 12'h102;
  localparam logic [11:0] REG_AUX_CUR      = 12'h200;
  localparam logic [11:0] REG_AUX_LAST     = 12'h201;
  localparam logic [11:0] REG_AUX_RATE     = 12'h210;
  localparam logic [11:0] REG_AUX_INSEL    = 12'h211;
  localparam logic [11:0] REG_XTAL_EN      = 12'h292;
  localparam logic [11:0] REG_EQ_CTRL      = 12'h301;

  // reset values
  localparam logic [15:0] RST_CLK_SRC      = 16'h0000;
  localparam logic [15:0] RST_PLL_FRACTION_DENOMINATOR      = 16'h0000;
  localparam logic [15:0] RST_PLL_NUM      = 16'h0000;
  localparam logic [15:0] RST_PLL_CTRL     = 16'h0000;
  localparam logic [15:0] RST_ROUTE        = 16'h0000;
  localparam logic [15:0] RST_AUX_RATE     = 16'h0000;
  localparam logic [15:0] RST_AUX_INSEL    = 16'h0000;
  localparam logic [15:0] RST_XTAL_EN      = 16'h0000;
  localparam logic [15:0] RST_EQ_CTRL      = 16'h0000;
  localparam logic [15:0] RST_AUX_RESULT   = 16'h0000;

  // field positions
  localparam int CLK_SRC_PLL_BIT   = 0;
  localparam int PLL_EN_BIT        = 0;
  localparam int PLL_FRAC_BIT      = 1;
  localparam int PLL_X_LSB         = 4;
  localparam int PLL_R_LSB         = 11;
  localparam int PLL_FIELD_W       = 4;
  localparam int LOCK_BIT          = 0;
  localparam int ROUTE_PATH_LSB    = 0;
  localparam int ROUTE_SWAP_BIT    = 2;
  localparam int AUX_RATE_FAST_BIT = 0;
  localparam int AUX_SINGLE_BIT    = 0;
  localparam int AUX_SINGLE_IN_BIT = 1;
  localparam int XTAL_EN_BIT       = 0;
  localparam int EQ_CUT_LSB        = 0;
  localparam int AUX_IN1_LSB       = 0;
  localparam int AUX_IN2_LSB       = 8;

  // serial frame layout: read flag, 3 unused bits, 12 address bits, 16 data bits
  localparam logic [5:0] SPI_HDR_BITS   = 6'd16;
  localparam logic [5:0] SPI_FRAME_BITS = 6'd32;

  // input path choices
  typedef enum logic [1:0] {
    AAPC_PATH_AMP,
    AAPC_PATH_AMP_EQ,
    AAPC_PATH_DIRECT,
    AAPC_PATH_AUX
  } aapc_path_t;

  // equalizer cutoff codes: 32, 37, 45, 54 kHz
  localparam logic [1:0] EQ_CUT_32K = 2'h0;

  // auxiliary conversion timing
  localparam int SYS_CLK_HZ       = 25000000;
  localparam int AUX_RATE_SLOW_HZ = 112500;
  localparam int AUX_RATE_FAST_HZ = 450000;
  // a slot is half a per-input period: two inputs alternate, or one input at twice the rate
  localparam int AUX_SLOT_SLOW_CYC = SYS_CLK_HZ / (2 * AUX_RATE_SLOW_HZ);
  localparam int AUX_SLOT_FAST_CYC = SYS_CLK_HZ / (2 * AUX_RATE_FAST_HZ);
endpackage

// ### verif/aapc_ctrl_checker.sv
// port assertions for the converter front-end control block
`timescale 1ns/1ps
module aapc_ctrl_checker
  import aapc_pkg::*;
#(
  parameter int SLOT_SLOW_CYC = 8,
  parameter int SLOT_FAST_CYC = 4
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  // serial port
  input wire logic        spi_cs_n,
  input wire logic        spi_miso_oe,
  // routing
  input wire aapc_path_t  route_path,
  input wire logic        eq_enable,
  input wire logic        aux_direct_pos_is_one,
  // auxiliary sequencer
  input wire logic        aux_conv_start,
  input wire logic        aux_chan_sel,
  // pll
  input wire logic        pll_frac_mode,
  input wire logic [15:0] pll_frac_num,
  input wire logic [15:0] pll_frac_den
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n || !clk_en);

  sequence s_slot_quiet;
    !aux_conv_start [*3];
  endsequence
  sequence s_sel_held;
    $stable(aux_chan_sel) [*3];
  endsequence

  property p_eq_path;
    eq_enable == (route_path == AAPC_PATH_AMP_EQ);
  endproperty
  property p_aux_leg;
    aux_direct_pos_is_one == (route_path == AAPC_PATH_AUX);
  endproperty
  property p_slot_gap;
    aux_conv_start |=> s_slot_quiet;
  endproperty
  property p_sel_at_start;
    $changed(aux_chan_sel) |-> aux_conv_start;
  endproperty
  property p_sel_hold;
    aux_conv_start |=> s_sel_held;
  endproperty
  property p_frac_ignored;
    !pll_frac_mode |-> (pll_frac_num == 16'h0000) && (pll_frac_den == 16'h0000);
  endproperty
  property p_oe_rise;
    $rose(spi_miso_oe) |-> !spi_cs_n;
  endproperty
  property p_oe_frame;
    spi_miso_oe |-> !$past(spi_cs_n, 6);
  endproperty

  a_eq_path: assert property (p_eq_path)
    else $error("eq enable does not follow path");
  a_aux_leg: assert property (p_aux_leg)
    else $error("aux leg flag does not follow path");
  a_slot_gap: assert property (p_slot_gap)
    else $error("conversion starts too close");
  a_sel_at_start: assert property (p_sel_at_start)
    else $error("input select moved outside a slot start");
  a_sel_hold: assert property (p_sel_hold)
    else $error("input select not held through slot");
  a_frac_ignored: assert property (p_frac_ignored)
    else $error("fraction values leak in integer mode");
  a_oe_rise: assert property (p_oe_rise)
    else $error("read data driven without select");
  a_oe_frame: assert property (p_oe_frame)
    else $error("read data driven outside a frame");
endmodule

// ### verif/aapc_ctrl_tb_top.sv
// self-checking bench for the converter front-end control block
`timescale 1ns/1ps
module aapc_ctrl_tb_top;
  import aapc_pkg::*;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  localparam int PH = 6;
  logic        sys_clk, arst_n, clk_en, spi_cs_n, spi_sclk, spi_mosi, aux_result_valid, pll_locked;
  logic [7:0]  aux_result;
  logic        spi_miso_o, spi_miso_oe, route_swap, eq_enable, aux_direct_pos_is_one, aux_conv_start;
  logic        aux_chan_sel, clk_src_pll, xtal_osc_en, pll_enable, pll_frac_mode;
  logic [1:0]  equalizer_cutoff_select, p;
  logic [3:0]  pll_mult_r, pll_div_x;
  logic [15:0] pll_frac_num, pll_frac_den, rd_word, cur_m, last_m;
  logic [15:0] exp_q[$];
  aapc_path_t  route_path;
  logic        resp_en, mode_ok, first, fast, single, sel_two, prev;
  int          err_count, checked, gap, seed;
  event        rd_ev;
  localparam logic [11:0] WA[9] = '{REG_CLK_SRC, REG_PLL_FRACTION_DENOMINATOR, REG_PLL_NUM, REG_PLL_CTRL, REG_ROUTE,
                                    REG_AUX_RATE, REG_AUX_INSEL, REG_XTAL_EN, REG_EQ_CTRL};
  localparam logic [15:0] WV[9] = '{16'h0001, 16'h000a, 16'h0002, 16'h3813, 16'h0006,
                                    16'h0001, 16'h0003, 16'h0001, 16'h0003};

  aapc_ctrl #(.SLOT_SLOW_CYC(SLOW), .SLOT_FAST_CYC(FAST)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .route_path(route_path),
    .route_swap(route_swap), .eq_enable(eq_enable), .equalizer_cutoff_select(equalizer_cutoff_select),
    .aux_direct_pos_is_one(aux_direct_pos_is_one), .aux_conv_start(aux_conv_start),
    .aux_chan_sel(aux_chan_sel), .aux_result(aux_result), .aux_result_valid(aux_result_valid),
    .clk_src_pll(clk_src_pll), .xtal_osc_en(xtal_osc_en), .pll_enable(pll_enable),
    .pll_frac_mode(pll_frac_mode), .pll_mult_r(pll_mult_r), .pll_div_x(pll_div_x),
    .pll_frac_num(pll_frac_num), .pll_frac_den(pll_frac_den), .pll_locked(pll_locked));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cmp_out(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] e, input logic [15:0] g);
    cmp_out(e, g);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one 32-bit frame, sclk idles high, bits driven on the fall
  task automatic spi(input logic rd, input logic [11:0] a, input logic [15:0] d);
    logic [31:0] f;
    logic [15:0] q;
    f = {rd, 3'h0, a, d};
    q = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (PH) @(negedge sys_clk);
      spi_sclk = 1'b0;
      spi_mosi = f[i];
      repeat (PH) @(negedge sys_clk);
      spi_sclk = 1'b1;
      if (i < 16) q[i] = spi_miso_o;
    end
    repeat (PH) @(negedge sys_clk);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (2 * PH) @(negedge sys_clk);
    if (rd) begin
      rd_word = q;
      ->rd_ev;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    spi(1'b1, a, 16'h0000);
  endtask

  // set an aux mode, let results arrive, then freeze them and read both result registers
  task automatic aux_run(input logic [15:0] rate, input logic [15:0] insel);
    @(posedge sys_clk) mode_ok = 1'b0;
    @(negedge sys_clk);
    spi(1'b0, REG_AUX_RATE, rate);
    spi(1'b0, REG_AUX_INSEL, insel);
    @(posedge sys_clk);
    {fast, single, sel_two} = {rate[0], insel[0], insel[1]};
    mode_ok = 1'b1;
    resp_en = 1'b1;
    repeat (120) @(posedge sys_clk);
    resp_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    rd(REG_AUX_CUR, cur_m);
    rd(REG_AUX_LAST, last_m);
    $display("aux test rate %h mode %h done", rate, insel);
  endtask

  always @(rd_ev) cmp_reg(exp_q.pop_front(), rd_word);

  // converter stand-in: while resp_en is high, answers each start half a cycle later
  always @(negedge sys_clk) begin
    aux_result_valid = aux_conv_start && resp_en;
    if (aux_result_valid) begin
      aux_result = 8'($random(seed));
      last_m = cur_m;
      if (aux_chan_sel) cur_m[15:8] = aux_result;
      else cur_m[7:0] = aux_result;
    end
  end

  // slot watcher: spacing and input order of conversion starts
  always @(negedge sys_clk) begin
    gap++;
    if (aux_conv_start) begin
      if (!mode_ok) first = 1'b1;
      else if (first) first = 1'b0;
      else begin
        cmp_out(fast ? 16'(FAST) : 16'(SLOW), 16'(gap));
        cmp_out({15'h0, single ? sel_two : !prev}, {15'h0, aux_chan_sel});
      end
      prev = aux_chan_sel;
      gap = 0;
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    seed = 70390;
    {arst_n, spi_sclk, spi_cs_n, spi_mosi, aux_result_valid, pll_locked} = 6'b011100;
    clk_en = 1'b1;
    {aux_result, cur_m, last_m, resp_en, mode_ok, first, gap} = '0;
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    cmp_out(16'h0000, {10'h0, route_path, route_swap, eq_enable, equalizer_cutoff_select});
    for (int i = 0; i < 9; i++) rd(WA[i], 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 9; i++) spi(1'b0, WA[i], WV[i]);
    for (int i = 0; i < 9; i++) rd(WA[i], WV[i]);
    cmp_out(16'h7103, {pll_mult_r, pll_div_x, 6'h0, pll_frac_mode, pll_enable});
    cmp_out(16'h0008, pll_frac_num ^ pll_frac_den);
    cmp_out(16'h000f, {12'h0, clk_src_pll, xtal_osc_en, equalizer_cutoff_select});
    spi(1'b0, REG_PLL_CTRL, 16'h3011);
    cmp_out(16'h6101, {pll_mult_r, pll_div_x, 6'h0, pll_frac_mode, pll_enable});
    cmp_out(16'h0000, pll_frac_num | pll_frac_den);
    $display("pll test done");
    for (int i = 0; i < 4; i++) begin
      p = i[1:0];
      spi(1'b0, REG_ROUTE, {13'h0, p[0], p});
      spi(1'b0, REG_EQ_CTRL, {14'h0, p});
      cmp_out({11'h0, p, p[0], p == 2'h1, p == 2'h3},
              {11'h0, route_path, route_swap, eq_enable, aux_direct_pos_is_one});
      cmp_out({14'h0, p}, {14'h0, equalizer_cutoff_select});
    end
    $display("routing test done");
    rd(REG_PLL_LOCK, 16'h0000);
    pll_locked = 1'b1;
    spi(1'b0, REG_PLL_LOCK, 16'h0000);
    rd(REG_PLL_LOCK, 16'h0001);
    rd(12'h7ff, 16'h0000);
    $display("lock test done");
    aux_run(16'h0000, 16'h0000);
    aux_run(16'h0001, 16'h0000);
    aux_run(16'h0001, 16'h0003);
    aux_run(16'h0000, 16'h0001);
    // a frame sent while the clock enable is low must leave no trace
    mode_ok = 1'b0;
    clk_en = 1'b0;
    spi(1'b0, REG_EQ_CTRL, 16'h0001);
    clk_en = 1'b1;
    cmp_out(16'h0003, {14'h0, equalizer_cutoff_select});
    rd(REG_EQ_CTRL, 16'h0003);
    $display("clock enable test done");
    spi(1'b0, REG_AUX_CUR, 16'hffff);
    rd(REG_AUX_CUR, cur_m);
    $display("read-only test done");
    give_verdict();
  end
endmodule

bind aapc_ctrl aapc_ctrl_checker #(.SLOT_SLOW_CYC(SLOT_SLOW_CYC), .SLOT_FAST_CYC(SLOT_FAST_CYC)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
  .route_path(route_path), .eq_enable(eq_enable), .aux_direct_pos_is_one(aux_direct_pos_is_one),
  .aux_conv_start(aux_conv_start), .aux_chan_sel(aux_chan_sel), .pll_frac_mode(pll_frac_mode),
  .pll_frac_num(pll_frac_num), .pll_frac_den(pll_frac_den));
